// File: hdl/io_buffer_unit_map.vh
// Summary of operation
// - Commands 0x0 to 0x3 load the input base, input limit, output base or output limit register with an io_buffer_ram address.
// - Command 0x4 adds its unsigned parameter to in_length and activates or reactivates peripheral service.
// - Command 0x5 adds its unsigned parameter to out_length.
// - Command 0x6, issued with a zero parameter, initializes control state other than the peripheral control register and deactivates peripheral service.
// - After a reset command, a later input length update reactivates peripheral service.
// - Command 0x7 loads the 12-bit parameter into the peripheral control register (host port for unit 0, serial port for unit 1).
// - Command 0x8 with a zero parameter stops input processing until a later input length update.
// - Each unit exposes a 10-bit input write pointer and a 10-bit output read pointer, with bits 31 to 10 reserved and read as zero.
`ifndef IO_BUFFER_UNIT_MAP_VH
`define IO_BUFFER_UNIT_MAP_VH
`define OP_IN_BASE 4'h0
`define OP_IN_LIMIT 4'h1
`define OP_OUT_BASE 4'h2
`define OP_OUT_LIMIT 4'h3
`define OP_IN_LEN_UP 4'h4
`define OP_OUT_LEN_UP 4'h5
`define OP_RESET 4'h6
`define OP_PCTL_LOAD 4'h7
`define OP_IN_DISABLE 4'h8
`define CMD_OP_HI 15
`define CMD_OP_LO 12
`define CMD_PARAM_HI 11
`define CMD_ADDR_HI 9
`define ADDR_CMD 12'h000
`define ADDR_IWP 12'h004
`define ADDR_ORP 12'h008
`define ADDR_IN_BASE 12'h00C
`define ADDR_IN_LIMIT 12'h010
`define ADDR_OUT_BASE 12'h014
`define ADDR_OUT_LIMIT 12'h018
`define ADDR_IN_LEN 12'h01C
`define ADDR_OUT_LEN 12'h020
`define ADDR_PCTL 12'h024
`define ADDR_STATUS 12'h028
`define ST_SERVICE 0
`define ST_INPUT 1
`define RST_ADDR 10'h000
`define RST_LEN 16'h0000
`define RST_PCTL 12'h000
`endif

// File: hdl/io_cmd_decode.v
`timescale 1ns/1ps
`include "io_buffer_unit_map.vh"
module io_cmd_decode (
	input wire [15:0] cmd, // Command word
	input wire cmd_valid, // Command written this cycle
	output reg [8:0] op_hit // One-hot decoded opcode
);
	always @* begin
		op_hit = 9'h000;
		// Codes 0x9 to 0xF match nothing and so do nothing.
		if (cmd_valid && cmd[`CMD_OP_HI:`CMD_OP_LO] <= `OP_IN_DISABLE) begin
			op_hit[cmd[`CMD_OP_HI:`CMD_OP_LO]] = 1'b1;
		end
	end
endmodule

// File: hdl/io_buffer_unit.v
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "io_buffer_unit_map.vh"
module io_buffer_unit #(
	parameter LEN_W = 16 // Width of the length counters
) (
	input wire hclk, // Core clock
	input wire hresetn, // Asynchronous reset, active low
	input wire ce, // Clock enable, freezes all state when low
	input wire hsel, // Slave select
	input wire [11:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write when high
	input wire [2:0] hsize, // Transfer size
	input wire hready, // Bus ready in
	input wire [31:0] hwdata, // Write data
	output wire [31:0] hrdata, // Read data
	output wire hreadyout, // Slave ready
	output wire hresp, // Response, always OKAY
	input wire iwp_adv, // Peripheral wrote a word to io_buffer_ram
	input wire orp_adv, // Peripheral read a word from io_buffer_ram
	output reg [9:0] in_buf_base_ff, // Input buffer base
	output reg [9:0] in_buf_limit_ff, // Input buffer limit
	output reg [9:0] out_buf_base_ff, // Output buffer base
	output reg [9:0] out_buf_limit_ff, // Output buffer limit
	output reg [LEN_W-1:0] in_length_ff, // Input length count
	output reg [LEN_W-1:0] out_length_ff, // Output length count
	output reg [11:0] periph_ctrl_ff, // Peripheral control register
	output reg [9:0] iwp_ff, // Input write pointer
	output reg [9:0] orp_ff, // Output read pointer
	output reg service_ff, // Peripheral service active
	output reg input_en_ff, // Input processing enabled
	output reg pctl_load // Pulse when periph_ctrl_ff is loaded
);
	reg req_ff;
	reg req_wr_ff;
	reg [11:0] req_addr_ff;
	wire [8:0] op_hit;
	wire cmd_valid;
	wire [11:0] param;
	wire [LEN_W-1:0] param_ext;
	wire [9:0] paddr;
	wire wr_iwp;
	wire wr_orp;
	reg [31:0] rd_mux;
	reg [31:0] hrdata_ff;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign cmd_valid = req_ff && req_wr_ff && req_addr_ff == `ADDR_CMD;
	assign param = hwdata[`CMD_PARAM_HI:0];
	assign param_ext = {{(LEN_W-12){1'b0}}, param};
	assign paddr = hwdata[`CMD_ADDR_HI:0];
	assign wr_iwp = req_ff && req_wr_ff && req_addr_ff == `ADDR_IWP;
	assign wr_orp = req_ff && req_wr_ff && req_addr_ff == `ADDR_ORP;

	io_cmd_decode u_dec (
		.cmd(hwdata[15:0]),
		.cmd_valid(cmd_valid),
		.op_hit(op_hit)
	);

	// Address phase capture; the data phase follows with zero wait.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_ff <= 1'b0;
			req_wr_ff <= 1'b0;
			req_addr_ff <= 12'h000;
		end else if (ce) begin
			req_ff <= hsel && hready && htrans[1];
			req_wr_ff <= hwrite;
			req_addr_ff <= haddr;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_buf_base_ff <= `RST_ADDR;
			in_buf_limit_ff <= `RST_ADDR;
			out_buf_base_ff <= `RST_ADDR;
			out_buf_limit_ff <= `RST_ADDR;
			in_length_ff <= `RST_LEN;
			out_length_ff <= `RST_LEN;
			periph_ctrl_ff <= `RST_PCTL;
			service_ff <= 1'b0;
			input_en_ff <= 1'b0;
			pctl_load <= 1'b0;
		end else if (ce) begin
			pctl_load <= 1'b0;
			if (op_hit[`OP_IN_BASE]) begin
				in_buf_base_ff <= paddr;
			end
			if (op_hit[`OP_IN_LIMIT]) begin
				in_buf_limit_ff <= paddr;
			end
			if (op_hit[`OP_OUT_BASE]) begin
				out_buf_base_ff <= paddr;
			end
			if (op_hit[`OP_OUT_LIMIT]) begin
				out_buf_limit_ff <= paddr;
			end
			if (op_hit[`OP_IN_LEN_UP]) begin
				in_length_ff <= in_length_ff + param_ext;
				service_ff <= 1'b1;
				input_en_ff <= 1'b1;
			end
			if (op_hit[`OP_OUT_LEN_UP]) begin
				out_length_ff <= out_length_ff + param_ext;
			end
			if (op_hit[`OP_RESET]) begin
				// Control state other than periph_ctrl_ff returns to its reset values.
				in_buf_base_ff <= `RST_ADDR;
				in_buf_limit_ff <= `RST_ADDR;
				out_buf_base_ff <= `RST_ADDR;
				out_buf_limit_ff <= `RST_ADDR;
				in_length_ff <= `RST_LEN;
				out_length_ff <= `RST_LEN;
				service_ff <= 1'b0;
				input_en_ff <= 1'b0;
			end
			if (op_hit[`OP_PCTL_LOAD]) begin
				periph_ctrl_ff <= param;
				pctl_load <= 1'b1;
			end
			if (op_hit[`OP_IN_DISABLE]) begin
				input_en_ff <= 1'b0;
			end
		end
	end

	// Pointers wrap from limit back to base; software may also write them.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iwp_ff <= `RST_ADDR;
			orp_ff <= `RST_ADDR;
		end else if (ce) begin
			if (op_hit[`OP_RESET]) begin
				iwp_ff <= `RST_ADDR;
				orp_ff <= `RST_ADDR;
			end else if (wr_iwp) begin
				iwp_ff <= paddr;
			end else if (iwp_adv && service_ff && input_en_ff) begin
				iwp_ff <= (iwp_ff == in_buf_limit_ff) ? in_buf_base_ff :
					iwp_ff + 10'h001;
			end
			if (op_hit[`OP_RESET]) begin
				orp_ff <= `RST_ADDR;
			end else if (wr_orp) begin
				orp_ff <= paddr;
			end else if (orp_adv && service_ff) begin
				orp_ff <= (orp_ff == out_buf_limit_ff) ? out_buf_base_ff :
					orp_ff + 10'h001;
			end
		end
	end

	always @* begin
		rd_mux = 32'h0000_0000;
		case (haddr)
		`ADDR_IWP: rd_mux = {22'h000000, iwp_ff};
		`ADDR_ORP: rd_mux = {22'h000000, orp_ff};
		`ADDR_IN_BASE: rd_mux = {22'h000000, in_buf_base_ff};
		`ADDR_IN_LIMIT: rd_mux = {22'h000000, in_buf_limit_ff};
		`ADDR_OUT_BASE: rd_mux = {22'h000000, out_buf_base_ff};
		`ADDR_OUT_LIMIT: rd_mux = {22'h000000, out_buf_limit_ff};
		`ADDR_IN_LEN: rd_mux = {{(32-LEN_W){1'b0}}, in_length_ff};
		`ADDR_OUT_LEN: rd_mux = {{(32-LEN_W){1'b0}}, out_length_ff};
		`ADDR_PCTL: rd_mux = {20'h00000, periph_ctrl_ff};
		`ADDR_STATUS: begin
			rd_mux[`ST_SERVICE] = service_ff;
			rd_mux[`ST_INPUT] = input_en_ff;
		end
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is registered at the address phase edge.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (ce && hsel && hready && htrans[1] && !hwrite) begin
			hrdata_ff <= rd_mux;
		end
	end
endmodule

// File: test/io_buffer_unit_asserts.sv
`timescale 1ns/1ps
`include "io_buffer_unit_map.vh"
module io_buffer_unit_asserts #(parameter LEN_W = 16) (
	input wire hclk, // clock
	input wire hresetn, // reset
	input wire hsel, // select
	input wire [11:0] haddr, // address
	input wire [1:0] htrans, // type
	input wire hwrite, // write
	input wire hready, // ready
	input wire [31:0] hwdata, // data
	input wire [9:0] in_buf_base_ff, // base
	input wire [9:0] out_buf_limit_ff, // limit
	input wire [LEN_W-1:0] in_length_ff, // count
	input wire [LEN_W-1:0] out_length_ff, // count
	input wire [11:0] periph_ctrl_ff, // control
	input wire service_ff, // service
	input wire input_en_ff, // input
	input wire pctl_load // pulse
);
reg cmd_ph_ff;
wire [3:0] op = hwdata[15:12];
// Marks the data phase of a command write, when hwdata holds the command.
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) cmd_ph_ff <= 1'b0;
	else cmd_ph_ff <= hsel & hready & htrans[1] & hwrite & (haddr == `ADDR_CMD);
end
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
AST_IN_BASE: assert property (cmd_ph_ff && op == `OP_IN_BASE |=>
	in_buf_base_ff == $past(hwdata[9:0])) else $error("in base wrong");
AST_OUT_LIMIT: assert property (cmd_ph_ff && op == `OP_OUT_LIMIT |=>
	out_buf_limit_ff == $past(hwdata[9:0])) else $error("out limit wrong");
AST_IN_LEN: assert property (cmd_ph_ff && op == `OP_IN_LEN_UP |=>
	in_length_ff == $past(in_length_ff) + $past(hwdata[11:0]) &&
	service_ff && input_en_ff) else $error("in length update wrong");
AST_OUT_LEN: assert property (cmd_ph_ff && op == `OP_OUT_LEN_UP |=>
	out_length_ff == $past(out_length_ff) + $past(hwdata[11:0]))
	else $error("out length update wrong");
AST_RESET: assert property (cmd_ph_ff && op == `OP_RESET |=>
	!service_ff && in_length_ff == 0) else $error("reset command wrong");
AST_PCTL: assert property (cmd_ph_ff && op == `OP_PCTL_LOAD |=>
	pctl_load && periph_ctrl_ff == $past(hwdata[11:0]))
	else $error("control load wrong");
AST_DISABLE: assert property (cmd_ph_ff && op == `OP_IN_DISABLE |=>
	!input_en_ff && service_ff == $past(service_ff))
	else $error("input disable wrong");
AST_RESERVED: assert property (cmd_ph_ff && op > `OP_IN_DISABLE |=>
	$stable(periph_ctrl_ff) && $stable(service_ff) && $stable(in_buf_base_ff))
	else $error("reserved opcode acted");
endmodule
bind io_buffer_unit io_buffer_unit_asserts #(.LEN_W(LEN_W))
	i_io_buffer_unit_asserts (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.in_buf_base_ff(in_buf_base_ff), .out_buf_limit_ff(out_buf_limit_ff),
	.in_length_ff(in_length_ff), .out_length_ff(out_length_ff),
	.periph_ctrl_ff(periph_ctrl_ff), .service_ff(service_ff),
	.input_en_ff(input_en_ff), .pctl_load(pctl_load));

// File: test/io_periph_model.sv
`timescale 1ns/1ps
module io_periph_model (
	input wire hclk, // clock
	input wire hresetn, // reset
	input wire go, // traffic allowed
	output reg iwp_adv, // wrote a word
	output reg orp_adv // read a word
);
reg tog_ff;
// Offers a word every other cycle while go is high; the unit itself must
// refuse write pointer moves while service or input is off, and read pointer moves while service is off.
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		tog_ff <= 1'b0;
		iwp_adv <= 1'b0;
		orp_adv <= 1'b0;
	end else begin
		tog_ff <= ~tog_ff;
		iwp_adv <= go & tog_ff;
		orp_adv <= go & tog_ff;
	end
end
endmodule

// File: test/io_buffer_unit_tb_top.sv
`timescale 1ns/1ps
`include "io_buffer_unit_map.vh"
module io_buffer_unit_tb_top;
reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
reg [11:0] haddr = 12'h000;
reg [1:0] htrans = 2'b00;
reg [31:0] hwdata = 32'h00000000, q, d;
wire [31:0] hrdata;
wire hreadyout, hresp, iwp_adv, orp_adv, service_ff, input_en_ff, pctl_load;
wire [9:0] in_buf_base_ff, in_buf_limit_ff, out_buf_base_ff;
wire [9:0] out_buf_limit_ff, iwp_ff, orp_ff;
wire [15:0] in_length_ff, out_length_ff;
wire [11:0] periph_ctrl_ff;
integer error_cnt = 0, n_compared = 0, cyc = 0, i;
reg [9:0] v [0:3];
always #20 hclk = ~hclk;
io_buffer_unit i_io_buffer_unit (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr,
	.htrans, .hwrite, .hsize(3'b010), .hready(hreadyout), .hwdata, .hrdata,
	.hreadyout, .hresp, .iwp_adv, .orp_adv, .in_buf_base_ff, .in_buf_limit_ff,
	.out_buf_base_ff, .out_buf_limit_ff, .in_length_ff, .out_length_ff,
	.periph_ctrl_ff, .iwp_ff, .orp_ff, .service_ff, .input_en_ff, .pctl_load);
io_periph_model i_io_periph_model (.hclk, .hresetn, .go, .iwp_adv, .orp_adv);
task xfer(input w, input [11:0] a, input [31:0] wd);
	hsel <= 1'b1;
	haddr <= a;
	htrans <= 2'b10;
	hwrite <= w;
	@(posedge hclk);
	while (hreadyout !== 1'b1) @(posedge hclk);
	htrans <= 2'b00;
	hsel <= 1'b0;
	hwdata <= wd;
	@(posedge hclk);
	while (hreadyout !== 1'b1) @(posedge hclk);
	q = hrdata;
	#1;
endtask
task cmd(input [3:0] o, input [11:0] p);
	xfer(1'b1, `ADDR_CMD, {16'h0000, o, p});
endtask
task chk(input [31:0] s, input [31:0] e, input string n);
	n_compared = n_compared + 1;
	if (s !== e) begin
		error_cnt = error_cnt + 1;
		$display("Error %0s expected %h seen %h", n, e, s);
	end
endtask
task conclude;
	$display("compared %0d errors %0d", n_compared, error_cnt);
	if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// The whole sequence needs well under 400 cycles.
always @(posedge hclk) begin
	cyc = cyc + 1;
	if (cyc == 3000) begin
		error_cnt = error_cnt + 1;
		conclude;
	end
end
initial begin
	v[0] = 10'h3FF;
	v[1] = 10'h001;
	v[2] = 10'h200;
	v[3] = 10'h2AA;
	repeat (10) @(posedge hclk);
	hresetn <= 1'b1;
	for (i = 0; i < 4; i = i + 1) begin
		cmd(i[3:0], {2'b00, v[i]});
		xfer(1'b0, `ADDR_IN_BASE + {i[9:0], 2'b00}, 32'h0);
		chk(q, v[i], "buffer bound");
	end
	chk({in_buf_base_ff, in_buf_limit_ff, out_buf_base_ff},
		{2'b00, v[0], v[1], v[2]}, "bound ports");
	chk({out_buf_limit_ff, hreadyout, hresp}, {v[3], 2'b10}, "limit port");
	cmd(`OP_IN_LEN_UP, 12'h7FF);
	cmd(`OP_IN_LEN_UP, 12'h001);
	chk(in_length_ff, 16'h0800, "in length");
	xfer(1'b0, `ADDR_STATUS, 32'h0);
	chk(q, 32'h3, "status");
	cmd(`OP_OUT_LEN_UP, 12'h7FF);
	cmd(`OP_OUT_LEN_UP, 12'h7FF);
	chk(out_length_ff, 16'h0FFE, "out length");
	go <= 1'b1;
	repeat (6) @(posedge hclk);
	cmd(`OP_IN_DISABLE, 12'h000);
	repeat (3) @(posedge hclk);
	xfer(1'b0, `ADDR_IWP, 32'h0);
	d = q;
	repeat (8) @(posedge hclk);
	xfer(1'b0, `ADDR_IWP, 32'h0);
	chk(q, d, "write pointer held");
	chk({q[31:10], service_ff, input_en_ff}, 24'h2, "disabled state");
	xfer(1'b1, `ADDR_IWP, 32'h000002AA);
	xfer(1'b0, `ADDR_IWP, 32'h0);
	chk(q, 32'h2AA, "write pointer");
	chk(iwp_ff, 10'h2AA, "write pointer port");
	xfer(1'b0, `ADDR_ORP, 32'h0);
	chk(q[31:10], 22'h0, "read pointer high");
	go <= 1'b0;
	cmd(`OP_IN_LEN_UP, 12'h000);
	chk(input_en_ff, 1'b1, "input resumed");
	cmd(`OP_PCTL_LOAD, 12'hA5C);
	chk({periph_ctrl_ff, pctl_load}, 13'h14B9, "control");
	for (i = 9; i < 16; i = i + 1) cmd(i[3:0], 12'hFFF);
	chk({periph_ctrl_ff, service_ff, pctl_load}, 14'h2972, "reserved");
	xfer(1'b1, 12'h0FC, 32'hFFFFFFFF);
	xfer(1'b0, 12'h0FC, 32'h0);
	chk(q, 32'h0, "unmapped");
	cmd(`OP_RESET, 12'h000);
	chk({service_ff, in_length_ff}, 17'h0, "reset");
	go <= 1'b1;
	repeat (6) @(posedge hclk);
	chk({iwp_ff, orp_ff}, 20'h0, "pointers idle");
	go <= 1'b0;
	cmd(`OP_IN_LEN_UP, 12'h003);
	chk({service_ff, in_length_ff}, 17'h10003, "reactivated");
	hresetn <= 1'b0;
	@(posedge hclk);
	chk({periph_ctrl_ff, service_ff, in_length_ff}, 29'h0, "hardware reset");
	hresetn <= 1'b1;
	cmd(`OP_PCTL_LOAD, 12'h123);
	chk(periph_ctrl_ff, 12'h123, "control after reset");
	conclude;
end
endmodule
